//--- testbench/vcs_reg_chk.sv
/*
 checker of the register port between host controller and register bank.
 assumes one clock and a synchronous active-low reset shared by both ends.
*/
module vcs_reg_chk
  import vcs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register port
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic interrupt_out_low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ack_answer; req && !ack |=> ack; endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("ack missing one cycle after request");
  property p_ack_end; ack |=> !ack && !req; endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("ack or request held past the answer");
  property p_ack_cause; ack |-> $past(req) && req; endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  property p_div_wr;
    req && we && addr == ADR_DIV_CTRL |-> wdata[15:6] == 10'h000 && !wdata[3]
      && wdata[2:0] != 3'b110 && wdata[2:0] != 3'b011;
  endproperty
  a_div_wr: assert property (p_div_wr)
    else $error("divider write with reserved bits or illegal code");
  property p_div_rd; ack && !we && addr == ADR_DIV_RD |-> rdata[15:6] == 10'h000 && !rdata[3];
  endproperty
  a_div_rd: assert property (p_div_rd)
    else $error("divider readback shows reserved bits");
  property p_cal_rd; ack && !we && addr == ADR_CAL_STAT |-> rdata[15:3] == 13'h0000; endproperty
  a_cal_rd: assert property (p_cal_rd)
    else $error("progress readback beyond bit two");
  property p_irq_off;
    req && !ack && we && addr == ADR_IRQ_EN && wdata[7:0] == 8'h00 |-> ##2 interrupt_out_low;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt low with all enables clear");
endmodule

//--- testbench/vcs_regs_tb.sv
/*
 testbench of host controller and register bank joined by the register port.
 assumes AXI4-Lite stimulus at 20 MHz and calibration results tied to constants.
*/
module vcs_cal_lo_divider_status_regs_tb import vcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic clk_ready, rf_cmp_hi, rf_cmp_lo, if_cmp_hi, if_cmp_lo, if_lock, rf_lock;
  logic rf_pll_en, if_pll_en, lo_divider_off;
  logic [1:0] if_output_divide_select;
  logic [4:0] if_divide_ratio;
  logic [2:0] lo_divide_select;
  logic [3:0] lo_divide_ratio;
  logic [15:0] if_cal_ref_count;
  logic [2:0] lo_c [6] = '{3'h7, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  int lo_r [6] = '{8, 6, 4, 2, 1, 0};
  int if_r [4] = '{1, 4, 8, 16};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  vcs_reg_if rif();
  vcs_host u_vcs_host(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rif(rif.host));
  vcs_device u_vcs_device(.aclk, .aresetn, .rif(rif.dev), .clk_ready, .rf_cmp_hi, .rf_cmp_lo,
    .if_cmp_hi, .if_cmp_lo, .if_lock, .rf_lock, .rf_pll_en, .if_pll_en,
    .bias_code_in(5'h15), .rf_code_in(9'h1A5), .if_code_in(9'h0C3), .if_output_divide_select,
    .if_divide_ratio, .lo_divide_select, .lo_divide_ratio, .lo_divider_off, .if_cal_ref_count);
  vcs_reg_chk u_vcs_reg_chk(.aclk, .aresetn, .req(rif.req), .we(rif.we), .addr(rif.addr),
    .wdata(rif.wdata), .rdata(rif.rdata), .ack(rif.ack),
    .interrupt_out_low(rif.interrupt_out_low));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      rsp = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      st = s_axi_rdata;
      rsp = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
    if (w) axi_wr(HOFS_WDATA, {16'h0000, d});
    axi_wr(HOFS_CMD, {23'h000000, w, a});
    do begin
      axi_rd(HOFS_STAT);
    end while (st[16] !== 1'b0);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    dev(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, st[15:0]});
  endtask

  task automatic setc(input logic [3:0] v);
    @(posedge aclk);
    {rf_cmp_hi, rf_cmp_lo, if_cmp_hi, if_cmp_lo} <= v;
    repeat (6) @(posedge aclk);
  endtask

  task automatic till(input int c);
    while (cyc < c) @(posedge aclk);
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {clk_ready, rf_cmp_hi, rf_cmp_lo, if_cmp_hi, if_cmp_lo, if_lock, rf_lock} = '0;
    {rf_pll_en, if_pll_en} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("ref count", 32'h000001C2, {16'h0000, if_cal_ref_count});
    chk("lo off", 32'h1, {31'h0, lo_divider_off});
    rchk(ADR_CAL_STAT, 16'h0000);
    rchk(ADR_DIV_RD, 16'h0000);
    axi_rd(4'hC);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_wr(4'hC, 32'h00000000);
    chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      dev(1'b1, ADR_DIV_CTRL, {10'h000, k[1:0], 1'b0, lo_c[k]});
      rchk(ADR_DIV_RD, {10'h000, k[1:0], 1'b0, lo_c[k]});
      chk("lo ratio", lo_r[k], {28'h0, lo_divide_ratio});
      chk("lo off", k == 5, {31'h0, lo_divider_off});
      chk("if ratio", if_r[k % 4], {27'h0, if_divide_ratio});
      chk("selects", {27'h0, lo_c[k], k[1:0]},
        {27'h0, lo_divide_select, if_output_divide_select});
    end
    dev(1'b1, ADR_DIV_CTRL, 16'h00FF);
    rchk(ADR_DIV_RD, 16'h0037);
    for (int k = 0; k < 2; k++) begin
      dev(1'b1, ADR_DIV_CTRL, k ? 16'h0003 : 16'h0006);
      chk("refused", 32'h1, {31'h0, st[18]});
      rchk(ADR_DIV_RD, 16'h0037);
    end
    axi_rd(HOFS_WDATA);
    chk("wdata word", 32'h00000003, st);
    axi_rd(HOFS_CMD);
    chk("cmd word", {24'h000000, ADR_DIV_RD}, st);
    $display("test divider done");
    dev(1'b1, ADR_IF_REF_CNT, 16'h01F4);
    chk("ref count", 32'h000001F4, {16'h0000, if_cal_ref_count});
    dev(1'b1, ADR_CAL_START, 16'h0007);
    t0 = cyc;
    rchk(ADR_CAL_STAT, 16'h0007);
    till(t0 + 9000);
    rchk(ADR_CAL_STAT, 16'h0006);
    till(t0 + 9100);
    rchk(ADR_CAL_STAT, 16'h0004);
    till(t0 + 10600);
    rchk(ADR_CAL_STAT, 16'h0004);
    till(t0 + 10750);
    rchk(ADR_CAL_STAT, 16'h0000);
    rchk(ADR_BIAS_RD, 16'h0015);
    rchk(ADR_RF_RD, 16'h01A5);
    rchk(ADR_IF_RD, 16'h00C3);
    $display("test calibration done");
    dev(1'b1, ADR_IRQ_EN, 16'h0000);
    @(posedge aclk);
    {rf_pll_en, clk_ready, if_lock, rf_lock} <= 4'hF;
    repeat (6) @(posedge aclk);
    rchk(ADR_DEV_STAT, 16'h0087);
    for (int k = 0; k < 4; k++) begin
      setc(4'h8 >> k);
      rchk(ADR_DEV_STAT, 16'h0087 | (16'h0040 >> k));
    end
    setc(4'h0);
    @(posedge aclk);
    rf_pll_en <= 1'b0;
    repeat (6) @(posedge aclk);
    rchk(ADR_DEV_STAT, 16'h0000);
    @(posedge aclk);
    if_pll_en <= 1'b1;
    repeat (6) @(posedge aclk);
    dev(1'b1, ADR_IRQ_EN, 16'h0042);
    chk("irq idle", 32'h1, {31'h0, rif.interrupt_out_low});
    setc(4'h8);
    chk("irq low", 32'h0, {31'h0, rif.interrupt_out_low});
    axi_rd(HOFS_STAT);
    chk("irq pending", 32'h1, {31'h0, st[17]});
    rchk(ADR_DEV_STAT, 16'h00C5);
    rchk(ADR_DEV_STAT, 16'h0085);
    chk("irq cleared", 32'h1, {31'h0, rif.interrupt_out_low});
    @(posedge aclk);
    if_lock <= 1'b0;
    repeat (6) @(posedge aclk);
    rchk(ADR_DEV_STAT, 16'h0083);
    $display("test status done");
    stop_test();
  end
endmodule

//--- verilog/vcs_cal_seq.sv
/*
 one calibration sequencer: busy from start until a duration in microseconds elapses.
 assumes a one-cycle microsecond tick on the same clock.
*/
module vcs_cal_seq #(
  parameter int DW = 18
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timing
  input wire logic tick,
  input wire logic [DW-1:0] dur_us,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  logic busy_r;
  logic [DW-1:0] cnt_r;

  assign busy = busy_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
    end else if (busy_r && tick && cnt_r >= dur_us) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= '0;
    end else if (busy_r && tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
    end else begin
      done <= busy_r && tick && (cnt_r >= dur_us) && !start;
    end
  end
endmodule

//--- verilog/vcs_device.sv
/*
 synthesiser register bank: timing and code registers, calibration sequencers,
 divider selection and the device status with latched events and interrupt.
 assumes condition inputs arrive asynchronously and are synchronised here.
*/
module vcs_device (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register port
  vcs_reg_if.dev rif,
  // analog conditions, asynchronous
  input wire logic clk_ready,
  input wire logic rf_cmp_hi,
  input wire logic rf_cmp_lo,
  input wire logic if_cmp_hi,
  input wire logic if_cmp_lo,
  input wire logic if_lock,
  input wire logic rf_lock,
  input wire logic rf_pll_en,
  input wire logic if_pll_en,
  // calibration results
  input wire logic [4:0] bias_code_in,
  input wire logic [8:0] rf_code_in,
  input wire logic [8:0] if_code_in,
  // divider and calibration settings out
  output logic [1:0] if_output_divide_select,
  output logic [4:0] if_divide_ratio,
  output logic [2:0] lo_divide_select,
  output logic [3:0] lo_divide_ratio,
  output logic lo_divider_off,
  output logic [15:0] if_cal_ref_count
);
  import vcs_pkg::*;

  logic [7:0] div_ctrl_r;
  logic [15:0] rf_startup_r;
  logic [15:0] if_ref_cnt_r;
  logic [15:0] if_settle_r;
  logic [15:0] if_startup_r;
  logic [7:0] irq_en_r;
  logic [4:0] bias_code_r;
  logic [8:0] rf_code_r;
  logic [8:0] if_code_r;
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [7:0] prev_r;
  logic [7:0] latch_r;
  logic [7:0] live;
  logic [7:0] evt;
  logic [7:0] stat_rd;
  logic ref_on;
  logic [4:0] tick_cnt_r;
  logic tick;
  logic ack_r;
  logic [15:0] rdata_r;
  logic take;
  logic wr;
  logic stat_clr;
  logic [2:0] start;
  logic [2:0] busy;
  logic [2:0] done;
  logic [17:0] dur [3];

  assign take = rif.req && !ack_r;
  assign wr = take && rif.we;
  assign stat_clr = take && !rif.we && rif.addr == ADR_DEV_STAT;
  assign rif.ack = ack_r;
  assign rif.rdata = rdata_r;

  // microsecond tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = tick_cnt_r == 5'(TICK_CYC - 1);

  // settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ctrl_r <= RST_DIV_CTRL;
      rf_startup_r <= RST_RF_STARTUP;
      if_ref_cnt_r <= RST_IF_REF_CNT;
      if_settle_r <= RST_IF_SETTLE;
      if_startup_r <= RST_IF_STARTUP;
      irq_en_r <= RST_IRQ_EN;
    end else if (wr) begin
      case (rif.addr)
        ADR_DIV_CTRL: div_ctrl_r <= rif.wdata[7:0];
        ADR_RF_STARTUP: rf_startup_r <= rif.wdata;
        ADR_IF_REF_CNT: if_ref_cnt_r <= rif.wdata;
        ADR_IF_SETTLE: if_settle_r <= rif.wdata;
        ADR_IF_STARTUP: if_startup_r <= rif.wdata;
        ADR_IRQ_EN: irq_en_r <= rif.wdata[7:0];
        default: ;
      endcase
    end
  end

  // calibration codes: written by software or loaded when a sequence ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_code_r <= '0;
      rf_code_r <= '0;
      if_code_r <= '0;
    end else begin
      if (done[CAL_BIAS]) begin
        bias_code_r <= bias_code_in;
      end else if (wr && rif.addr == ADR_BIAS_CODE) begin
        bias_code_r <= rif.wdata[4:0];
      end
      if (done[CAL_RF]) begin
        rf_code_r <= rf_code_in;
      end else if (wr && rif.addr == ADR_RF_CODE) begin
        rf_code_r <= rif.wdata[8:0];
      end
      if (done[CAL_IF]) begin
        if_code_r <= if_code_in;
      end else if (wr && rif.addr == ADR_IF_CODE) begin
        if_code_r <= rif.wdata[8:0];
      end
    end
  end

  // calibration sequencers
  assign start = (wr && rif.addr == ADR_CAL_START) ? rif.wdata[2:0] : 3'h0;
  assign dur[CAL_BIAS] = 18'(BIAS_CAL_US);
  assign dur[CAL_RF] = 18'(rf_startup_r) + 18'(RF_SETTLE_US);
  assign dur[CAL_IF] = 18'(if_startup_r)
    + (18'(if_settle_r[15:8]) << SETTLE_UNIT_SHIFT)
    + (18'(if_settle_r[7:0]) << SETTLE_UNIT_SHIFT);

  for (genvar c = 0; c < 3; c++) begin : g_cal
    vcs_cal_seq #(.DW(18)) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .dur_us(dur[c]),
      .start(start[c]),
      .busy(busy[c]),
      .done(done[c])
    );
  end

  // condition synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {clk_ready, rf_cmp_hi, rf_cmp_lo, if_cmp_hi, if_cmp_lo,
        if_lock, rf_lock, rf_pll_en, if_pll_en};
      sync2_r <= sync1_r;
    end
  end

  assign ref_on = sync2_r[1] || sync2_r[0];
  assign live = ref_on ? {sync2_r[8:4], sync2_r[3] & sync2_r[2], sync2_r[3:2]} : 8'h00;
  assign evt = (live & ~prev_r & ~EDGE_FALL_MASK) | (~live & prev_r & EDGE_FALL_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= live;
    end
  end

  // status bits, live or latched
  for (genvar b = 0; b < 8; b++) begin : g_stat
    always_ff @(posedge aclk) begin
      if (!aresetn || !ref_on) begin
        latch_r[b] <= 1'b0;
      end else if (irq_en_r[b] && evt[b]) begin
        latch_r[b] <= 1'b1;
      end else if (stat_clr || !irq_en_r[b]) begin
        latch_r[b] <= 1'b0;
      end
    end
    assign stat_rd[b] = irq_en_r[b] ? latch_r[b] : live[b];
  end

  assign rif.interrupt_out_low = ~|(latch_r & irq_en_r);

  // register answer, one cycle after the request is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= '0;
    end else if (take && !rif.we) begin
      case (rif.addr)
        ADR_BIAS_RD: rdata_r <= {11'h000, bias_code_r};
        ADR_RF_RD: rdata_r <= {7'h00, rf_code_r};
        ADR_IF_RD: rdata_r <= {7'h00, if_code_r};
        ADR_CAL_STAT: rdata_r <= {13'h0000, busy};
        ADR_DEV_STAT: rdata_r <= {8'h00, stat_rd};
        ADR_DIV_RD: rdata_r <= {8'h00, div_ctrl_r};
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  // divider decode
  assign if_output_divide_select = div_ctrl_r[5:4];
  assign lo_divide_select = div_ctrl_r[2:0];
  assign if_cal_ref_count = if_ref_cnt_r;

  always_comb begin
    case (div_ctrl_r[5:4])
      2'b00: if_divide_ratio = 5'h01;
      2'b01: if_divide_ratio = 5'h04;
      2'b10: if_divide_ratio = 5'h08;
      default: if_divide_ratio = 5'h10;
    endcase
  end

  always_comb begin
    lo_divider_off = 1'b0;
    case (div_ctrl_r[2:0])
      3'b111: lo_divide_ratio = 4'h8;
      3'b101: lo_divide_ratio = 4'h6;
      3'b100: lo_divide_ratio = 4'h4;
      3'b010: lo_divide_ratio = 4'h2;
      3'b001: lo_divide_ratio = 4'h1;
      default: begin
        lo_divide_ratio = 4'h0;
        lo_divider_off = 1'b1;
      end
    endcase
  end
endmodule

//--- verilog/vcs_host.sv
/*
 host controller: AXI4-Lite slave with command, write-data and status words,
 driving the register port of the synthesiser register bank.
 assumes the bank answers each request with a one-cycle ack.
*/
module vcs_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register port
  vcs_reg_if.host rif
);
  import vcs_pkg::*;

  vcs_hstate_t st_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [15:0] wreg_r;
  logic [15:0] rd_r;
  logic refused_r;
  logic [7:0] addr_r;
  logic we_r;
  logic [15:0] out_r;
  logic do_wr;
  logic cmd_go;
  logic cmd_bad;
  logic [15:0] div_clean;

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign cmd_go = do_wr && awaddr_r == HOFS_CMD && st_r == VCS_H_IDLE && wstrb_r != 4'h0;
  // divider control: reserved bits forced to zero, illegal lo codes refused
  assign div_clean = wreg_r & {8'h00, DIV_CTRL_MASK};
  assign cmd_bad = wdata_r[HCMD_WE_BIT] && wdata_r[7:0] == ADR_DIV_CTRL
    && (wreg_r[2:0] == 3'b110 || wreg_r[2:0] == 3'b011);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && !w_hold_r) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_wr) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == HOFS_CMD || awaddr_r == HOFS_WDATA) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreg_r <= '0;
    end else if (do_wr && awaddr_r == HOFS_WDATA) begin
      wreg_r <= wdata_r[15:0];
    end
  end

  // register port sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= VCS_H_IDLE;
      addr_r <= '0;
      we_r <= 1'b0;
      out_r <= '0;
      rd_r <= '0;
      refused_r <= 1'b0;
    end else begin
      case (st_r)
        VCS_H_IDLE: begin
          if (cmd_go && cmd_bad) begin
            refused_r <= 1'b1;
          end else if (cmd_go) begin
            refused_r <= 1'b0;
            addr_r <= wdata_r[7:0];
            we_r <= wdata_r[HCMD_WE_BIT];
            out_r <= (wdata_r[7:0] == ADR_DIV_CTRL) ? div_clean : wreg_r;
            st_r <= VCS_H_BUSY;
          end
        end
        VCS_H_BUSY: begin
          if (rif.ack) begin
            if (!we_r) begin
              rd_r <= rif.rdata;
            end
            st_r <= VCS_H_IDLE;
          end
        end
        default: st_r <= VCS_H_IDLE;
      endcase
    end
  end

  assign rif.req = st_r == VCS_H_BUSY;
  assign rif.we = we_r;
  assign rif.addr = addr_r;
  assign rif.wdata = out_r;

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        HOFS_CMD: s_axi_rdata <= {23'h000000, we_r, addr_r};
        HOFS_WDATA: s_axi_rdata <= {16'h0000, wreg_r};
        HOFS_STAT: s_axi_rdata <= {13'h0000, refused_r, ~rif.interrupt_out_low,
          st_r == VCS_H_BUSY, rd_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- verilog/vcs_pkg.sv
/*
 package of the synthesiser register bank: offsets, reset values, field positions,
 timing counts and host-side offsets and states.
 assumes a single 20 MHz clock shared by both ends.
*/
package vcs_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_HZ = 1_000_000;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int BIAS_CAL_US = 6;
  localparam int RF_SETTLE_US = 152;
  localparam int SETTLE_UNIT_SHIFT = 3;
  localparam logic [7:0] ADR_CAL_START = 8'h50;
  localparam logic [7:0] ADR_BIAS_CODE = 8'h51;
  localparam logic [7:0] ADR_RF_CODE = 8'h53;
  localparam logic [7:0] ADR_DIV_CTRL = 8'h3F;
  localparam logic [7:0] ADR_RF_STARTUP = 8'h56;
  localparam logic [7:0] ADR_IF_CODE = 8'h57;
  localparam logic [7:0] ADR_IF_REF_CNT = 8'h58;
  localparam logic [7:0] ADR_IF_SETTLE = 8'h59;
  localparam logic [7:0] ADR_IF_STARTUP = 8'h5A;
  localparam logic [7:0] ADR_BIAS_RD = 8'h5B;
  localparam logic [7:0] ADR_RF_RD = 8'h5C;
  localparam logic [7:0] ADR_IF_RD = 8'h5D;
  localparam logic [7:0] ADR_CAL_STAT = 8'h5E;
  localparam logic [7:0] ADR_DEV_STAT = 8'hC4;
  localparam logic [7:0] ADR_IRQ_EN = 8'hC5;
  localparam logic [7:0] ADR_DIV_RD = 8'hCF;
  localparam logic [7:0] RST_DIV_CTRL = 8'h00;
  localparam logic [15:0] RST_RF_STARTUP = 16'h012C;
  localparam logic [15:0] RST_IF_REF_CNT = 16'h01C2;
  localparam logic [15:0] RST_IF_SETTLE = 16'h0D0D;
  localparam logic [15:0] RST_IF_STARTUP = 16'h0145;
  localparam logic [7:0] RST_IRQ_EN = 8'h80;
  localparam logic [7:0] DIV_CTRL_MASK = 8'h37;
  localparam logic [7:0] EDGE_FALL_MASK = 8'h07;
  localparam int CAL_IF = 2;
  localparam int CAL_RF = 1;
  localparam int CAL_BIAS = 0;
  localparam logic [3:0] HOFS_CMD = 4'h0;
  localparam logic [3:0] HOFS_WDATA = 4'h4;
  localparam logic [3:0] HOFS_STAT = 4'h8;
  localparam int HCMD_WE_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [0:0] {VCS_H_IDLE, VCS_H_BUSY} vcs_hstate_t;
endpackage

//--- verilog/vcs_reg_if.sv
/*
 register port joining the host controller and the synthesiser register bank.
 assumes both ends run on the same clock; req holds until the one-cycle ack.
*/
interface vcs_reg_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic interrupt_out_low;
  modport dev (input req, input we, input addr, input wdata,
    output rdata, output ack, output interrupt_out_low);
  modport host (output req, output we, output addr, output wdata,
    input rdata, input ack, input interrupt_out_low);
endinterface
